// File: include/tbid_pkg.sv
// Functional notes
// - Each instruction arrives as one 12-bit word holding an opcode part and operand parts.
// - Every word is classed into exactly one family: byte-file, bit-file, or literal/control.
// - A byte-file operation with result_target 0 sends its result to the accumulator.
// - A byte-file operation with result_target 1 writes back to the addressed file register.
// - Byte-file words carry a 5-bit register_operand and a 1-bit result_target.
// - Bit-file words carry a 3-bit position_select and a 5-bit register_operand.
// - Literal/control words other than jump_absolute carry an 8-bit immediate_value.
// - The jump_absolute word carries a 9-bit immediate_value that is the jump target.
// - The file register space addressed spans 0x00 to 0x7f; the decoder only forms 0x00 to 0x1f from the 5-bit register_operand.
// - An instruction takes one instruction cycle unless a test is true or the PC changes.
// - A true test or a PC change makes the instruction take two instruction cycles.
// - One instruction cycle is four consecutive oscillator periods.
// - Ignored bit positions may hold any value and do not influence decoding.
package tbid_pkg;
  localparam int unsigned TBID_IW = 12;
  localparam int unsigned TBID_FA_W = 7;
  localparam logic [6:0] TBID_FA_MAX = 7'h7f;
  localparam int unsigned TBID_PERIODS = 4;
  // Field positions
  localparam int unsigned TBID_BYTE_OP_HI = 11;
  localparam int unsigned TBID_BYTE_OP_LO = 6;
  localparam int unsigned TBID_TGT_BIT = 5;
  localparam int unsigned TBID_REG_HI = 4;
  localparam int unsigned TBID_REG_LO = 0;
  localparam int unsigned TBID_BIT_OP_HI = 11;
  localparam int unsigned TBID_BIT_OP_LO = 8;
  localparam int unsigned TBID_POS_HI = 7;
  localparam int unsigned TBID_POS_LO = 5;
  localparam int unsigned TBID_JMP_OP_HI = 11;
  localparam int unsigned TBID_JMP_OP_LO = 9;
  localparam int unsigned TBID_LIT_HI = 7;
  localparam int unsigned TBID_JLIT_HI = 8;
  // Family codes on the top two opcode bits
  localparam logic [1:0] TBID_TOP_BYTE = 2'h0;
  localparam logic [1:0] TBID_TOP_BIT = 2'h1;
  localparam logic [2:0] TBID_JMP_CODE = 3'h5;
  // Bit-file sub-opcodes: clear, set, test-clear-skip, test-set-skip
  localparam logic [1:0] TBID_BOP_CLR = 2'h0;
  localparam logic [1:0] TBID_BOP_SET = 2'h1;
  localparam logic [1:0] TBID_BOP_TSC = 2'h2;
  localparam logic [1:0] TBID_BOP_TSS = 2'h3;
  // Byte opcodes that skip on zero result (decrement/increment skip)
  localparam logic [5:0] TBID_OP_DECSZ = 6'h0b;
  localparam logic [5:0] TBID_OP_INCSZ = 6'h0f;
  // File register that holds the low program counter byte
  localparam logic [4:0] TBID_REG_PC = 5'h02;
  // Literal/control opcodes (bits 11:8) that change the PC
  localparam logic [3:0] TBID_LOP_RET = 4'h8;
  localparam logic [3:0] TBID_LOP_CALL = 4'h9;
  localparam logic [2:0] TBID_PH_INIT = 3'h0;
  localparam logic [1:0] TBID_Q_INIT = 2'h0;

  typedef enum logic [1:0] {
    TBID_FAM_BYTE = 2'h0,
    TBID_FAM_BIT = 2'h1,
    TBID_FAM_LIT = 2'h3
  } tbid_fam_e;

  // Sequencer: fetch/decode cycle, then optional second cycle (Gray path)
  typedef enum logic [1:0] {
    TBID_ST_IDLE = 2'h0,
    TBID_ST_EXEC = 2'h1,
    TBID_ST_EXTRA = 2'h3
  } tbid_st_e;
endpackage

// File: core/tbid_field.sv
`timescale 1ns/1ps
`default_nettype none
// Pure field extraction; kept apart so the sequencer stays readable.
module tbid_field
  import tbid_pkg::*;
(
  // Instruction word
  input wire logic [TBID_IW-1:0] word,
  // Decoded fields
  output tbid_fam_e family,
  output logic target,
  output logic [4:0] reg_operand,
  output logic [2:0] position_select,
  output logic [7:0] imm8,
  output logic [8:0] imm9,
  output logic is_jump,
  output logic may_skip,
  output logic pc_change
);
  logic [1:0] top;
  logic [5:0] bop;
  logic [3:0] lop;
  always_comb begin
    top = word[TBID_BYTE_OP_HI -: 2];
    bop = word[TBID_BYTE_OP_HI:TBID_BYTE_OP_LO];
    lop = word[TBID_BIT_OP_HI:TBID_BIT_OP_LO];
    // Every word lands in one family only; only named fields are read
    if (top == TBID_TOP_BYTE) begin
      family = TBID_FAM_BYTE;
    end else if (top == TBID_TOP_BIT) begin
      family = TBID_FAM_BIT;
    end else begin
      family = TBID_FAM_LIT;
    end
    target = word[TBID_TGT_BIT];
    reg_operand = word[TBID_REG_HI:TBID_REG_LO];
    position_select = word[TBID_POS_HI:TBID_POS_LO];
    imm8 = word[TBID_LIT_HI:0];
    imm9 = word[TBID_JLIT_HI:0];
    is_jump = (word[TBID_JMP_OP_HI:TBID_JMP_OP_LO] == TBID_JMP_CODE);
    may_skip = 1'b0;
    pc_change = 1'b0;
    case (family)
      TBID_FAM_BYTE: begin
        may_skip = (bop == TBID_OP_DECSZ) || (bop == TBID_OP_INCSZ);
        // Writing the PC file register also changes flow
        pc_change = target && (reg_operand == TBID_REG_PC);
      end
      TBID_FAM_BIT: begin
        may_skip = (lop[1:0] == TBID_BOP_TSC) || (lop[1:0] == TBID_BOP_TSS);
        pc_change = (lop[1:0] != TBID_BOP_CLR) && (lop[1:0] != TBID_BOP_SET)
          ? 1'b0 : (reg_operand == TBID_REG_PC);
      end
      default: begin
        pc_change = is_jump || (lop == TBID_LOP_RET) || (lop == TBID_LOP_CALL);
      end
    endcase
  end
endmodule
`default_nettype wire

// File: core/tbid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Latches one word per instruction cycle, presents decoded fields from flops and
// sequences the four oscillator periods, stretching to two cycles when needed.
module tbid_decoder
  import tbid_pkg::*;
#(
  parameter int unsigned PERIODS = TBID_PERIODS
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Program memory side
  input wire logic [TBID_IW-1:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // Condition outcome from the datapath, same clock
  input wire logic test_true,
  // Decoded outputs
  output tbid_fam_e family,
  output logic [TBID_FA_W-1:0] file_addr,
  output logic [2:0] position_select,
  output logic [7:0] immediate_value,
  output logic [8:0] jump_target,
  output logic jump_absolute,
  output logic write_accum,
  output logic write_file,
  output logic pc_change,
  output logic two_cycle,
  // Sequencing
  output logic [1:0] q_phase,
  output logic cycle_end
);
  // q is two bits wide, so only a four-period cycle can be counted
  if (PERIODS != TBID_PERIODS) begin : g_periods_check
    $error("PERIODS must be 4");
  end

  // Decoded fields live in the state so they leave from flops
  typedef struct packed {
    tbid_fam_e fam;
    logic [TBID_FA_W-1:0] fa;
    logic [2:0] pos;
    logic [7:0] imm;
    logic [8:0] jt;
    logic jmp;
    logic wa;
    logic wf;
    logic pcc;
  } tbid_out_s;

  typedef struct packed {
    tbid_st_e st;
    logic [1:0] q;
    logic [TBID_IW-1:0] word;
    logic two;
    tbid_out_s o;
  } tbid_state_s;

  tbid_state_s cur;
  tbid_state_s next_cur;

  tbid_fam_e d_fam;
  logic d_tgt, d_jmp, d_skip, d_pc;
  logic [4:0] d_reg;
  logic [2:0] d_pos;
  logic [7:0] d_imm8;
  logic [8:0] d_imm9;
  logic last_q;
  logic [1:0] word_top;

  tbid_field u_field (
    .word(cur.word),
    .family(d_fam),
    .target(d_tgt),
    .reg_operand(d_reg),
    .position_select(d_pos),
    .imm8(d_imm8),
    .imm9(d_imm9),
    .is_jump(d_jmp),
    .may_skip(d_skip),
    .pc_change(d_pc)
  );

  assign last_q = (cur.q == 2'(PERIODS - 1));
  assign word_top = cur.word[TBID_BYTE_OP_HI -: 2];
  assign instr_ready = (cur.st == TBID_ST_IDLE) || ((cur.st == TBID_ST_EXEC) && last_q && !cur.two)
    || ((cur.st == TBID_ST_EXTRA) && last_q);

  always_comb begin
    next_cur = cur;
    case (cur.st)
      TBID_ST_IDLE: begin
        if (instr_valid) begin
          next_cur.word = instr_word;
          next_cur.st = TBID_ST_EXEC;
          next_cur.q = TBID_Q_INIT;
          next_cur.two = 1'b0;
        end
      end
      TBID_ST_EXEC: begin
        next_cur.q = cur.q + 2'h1;
        // Test outcome counts only in the first period; later changes are ignored
        if (cur.q == TBID_Q_INIT) begin
          next_cur.two = d_pc || (d_skip && test_true);
        end
        if (last_q) begin
          if (cur.two) begin
            next_cur.st = TBID_ST_EXTRA;
          end else if (instr_valid) begin
            next_cur.word = instr_word;
            next_cur.two = 1'b0;
          end else begin
            next_cur.st = TBID_ST_IDLE;
          end
        end
      end
      TBID_ST_EXTRA: begin
        next_cur.q = cur.q + 2'h1;
        if (last_q) begin
          next_cur.two = 1'b0;
          if (instr_valid) begin
            next_cur.word = instr_word;
            next_cur.st = TBID_ST_EXEC;
          end else begin
            next_cur.st = TBID_ST_IDLE;
          end
        end
      end
      default: begin
        next_cur.st = TBID_ST_IDLE;
      end
    endcase
    // Re-registered every cycle from the held word, so fields stand all cycle
    next_cur.o.fam = d_fam;
    next_cur.o.fa = TBID_FA_W'(d_reg);
    next_cur.o.pos = (d_fam == TBID_FAM_BIT) ? d_pos : 3'h0;
    next_cur.o.imm = d_imm8;
    next_cur.o.jt = d_imm9;
    next_cur.o.jmp = (d_fam == TBID_FAM_LIT) && d_jmp;
    next_cur.o.wa = (d_fam == TBID_FAM_BYTE) && !d_tgt;
    next_cur.o.wf = (d_fam == TBID_FAM_BYTE) && d_tgt;
    next_cur.o.pcc = d_pc;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{st: TBID_ST_IDLE, q: TBID_Q_INIT, word: '0, two: 1'b0,
               o: '{fam: TBID_FAM_BYTE, fa: '0, pos: '0, imm: '0, jt: '0, jmp: 1'b0,
                    wa: 1'b0, wf: 1'b0, pcc: 1'b0}};
    end else begin
      cur <= next_cur;
    end
  end

  assign family = cur.o.fam;
  assign file_addr = cur.o.fa;
  assign position_select = cur.o.pos;
  assign immediate_value = cur.o.imm;
  assign jump_target = cur.o.jt;
  assign jump_absolute = cur.o.jmp;
  assign write_accum = cur.o.wa;
  assign write_file = cur.o.wf;
  assign pc_change = cur.o.pcc;
  assign two_cycle = cur.two;
  assign q_phase = cur.q;
  assign cycle_end = (cur.st != TBID_ST_IDLE) && last_q;

  // Assertions
  sequence s_cycle_start;
    (cur.st == TBID_ST_EXEC) && (cur.q == TBID_Q_INIT);
  endsequence
  sequence s_four_periods;
    (cur.q == 2'h1) ##1 (cur.q == 2'h2) ##1 (cur.q == 2'h3);
  endsequence
  sequence s_extra_cycle;
    (cur.st == TBID_ST_EXTRA) [*4];
  endsequence

  chk_cycle_four_periods: assert property (@(posedge mclk) disable iff (!rst_n)
    s_cycle_start |=> s_four_periods)
    else $error("instruction cycle not four periods");
  chk_accum_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_fam == TBID_FAM_BYTE && !d_tgt) |=> (write_accum && !write_file))
    else $error("target 0 did not select accumulator");
  chk_file_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_fam == TBID_FAM_BYTE && d_tgt) |=> (write_file && file_addr == TBID_FA_W'($past(d_reg))))
    else $error("target 1 did not select file register");
  chk_family_unique: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (((family == TBID_FAM_BYTE) == ($past(word_top) == TBID_TOP_BYTE))
      && ((family == TBID_FAM_BIT) == ($past(word_top) == TBID_TOP_BIT))
      && ((family == TBID_FAM_LIT) == $past(word_top[1]))))
    else $error("family not one of three");
  chk_jump_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (cur.word[TBID_JMP_OP_HI:TBID_JMP_OP_LO] == TBID_JMP_CODE)
      |=> (jump_absolute && (jump_target == $past(cur.word[TBID_JLIT_HI:0]))))
    else $error("jump target wrong");
  chk_imm_eight: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (immediate_value == $past(cur.word[TBID_LIT_HI:0])))
    else $error("immediate value wrong");
  chk_bit_position: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_fam == TBID_FAM_BIT) |=> (position_select == $past(cur.word[TBID_POS_HI:TBID_POS_LO])))
    else $error("bit position wrong");
  chk_addr_range: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (file_addr <= TBID_FA_MAX)
      && (file_addr == TBID_FA_W'($past(cur.word[TBID_REG_HI:TBID_REG_LO]))))
    else $error("file address out of range");
  chk_two_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    (cur.st == TBID_ST_EXEC && last_q && cur.two) |=> s_extra_cycle)
    else $error("second cycle not four periods");
  chk_single_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    (cur.st == TBID_ST_EXEC && last_q && !cur.two) |=> (cur.st != TBID_ST_EXTRA))
    else $error("plain instruction stretched");
  chk_ready_refused: assert property (@(posedge mclk) disable iff (!rst_n)
    ((cur.st != TBID_ST_IDLE) && !last_q) |-> !instr_ready)
    else $error("word taken inside an instruction cycle");
  chk_skip_stretch: assert property (@(posedge mclk) disable iff (!rst_n)
    s_cycle_start ##0 (d_pc || (d_skip && test_true)) |=> two_cycle)
    else $error("taken test or flow change not stretched");
  chk_plain_single: assert property (@(posedge mclk) disable iff (!rst_n)
    s_cycle_start ##0 !(d_pc || (d_skip && test_true)) |=> !two_cycle)
    else $error("plain instruction marked two-cycle");
endmodule
`default_nettype wire

// File: test/tbid_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tbid_prog_mem
  import tbid_pkg::*;
#(
  parameter int N = 16
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench control
  input wire logic [TBID_IW-1:0] words [N],
  input wire logic slow,
  // Fetch handshake
  input wire logic instr_ready,
  output logic [TBID_IW-1:0] instr_word,
  output logic instr_valid
);
  int idx;
  int stall;
  logic [TBID_IW-1:0] held;
  // Words go out exactly as given, ignored bits included
  assign instr_valid = rst_n && (stall == 0) && (idx < N);
  // Toggle an unheld bus so a stale word never looks valid
  assign instr_word = instr_valid ? words[idx] : ~held;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 0;
      stall <= 0;
      held <= '0;
    end else begin
      held <= instr_word;
      if (instr_valid && instr_ready) begin
        idx <= idx + 1;
        stall <= slow ? 6 : 0;
      end else if (stall > 0) begin
        stall <= stall - 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tbid_pkg::*;
;
  typedef struct packed {
    logic [11:0] word;
    logic tt;
    logic [1:0] fam;
    logic pc;
    logic two;
  } tbid_row_s;
  localparam int NR = 16;
  localparam tbid_row_s ROWS [NR] = '{
    '{12'h1e5, 1'h0, 2'h0, 1'h0, 1'h0}, '{12'h1c5, 1'h1, 2'h0, 1'h0, 1'h0},
    '{12'h2ff, 1'h1, 2'h0, 1'h0, 1'h1}, '{12'h2ff, 1'h0, 2'h0, 1'h0, 1'h0},
    '{12'h3c0, 1'h1, 2'h0, 1'h0, 1'h1}, '{12'h4ff, 1'h1, 2'h1, 1'h0, 1'h0},
    '{12'h500, 1'h0, 2'h1, 1'h0, 1'h0}, '{12'h66a, 1'h1, 2'h1, 1'h0, 1'h1},
    '{12'h66a, 1'h0, 2'h1, 1'h0, 1'h0}, '{12'h7a1, 1'h0, 2'h1, 1'h0, 1'h0},
    '{12'h7a1, 1'h1, 2'h1, 1'h0, 1'h1}, '{12'hc3a, 1'h1, 2'h3, 1'h0, 1'h0},
    '{12'h855, 1'h0, 2'h3, 1'h1, 1'h1}, '{12'h9ab, 1'h0, 2'h3, 1'h1, 1'h1},
    '{12'hb7f, 1'h0, 2'h3, 1'h1, 1'h1}, '{12'h1e2, 1'h0, 2'h0, 1'h1, 1'h1}};
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic test_true = 1'h0;
  logic slow = 1'h0;
  logic [11:0] words [NR];
  wire [11:0] instr_word;
  wire instr_valid, instr_ready, jump_absolute, write_accum, write_file, pc_change;
  wire two_cycle, cycle_end;
  tbid_fam_e family;
  wire [6:0] file_addr;
  wire [2:0] position_select;
  wire [7:0] immediate_value;
  wire [8:0] jump_target;
  wire [1:0] q_phase;
  wire [33:0] actual;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  assign actual = {family, file_addr, position_select, immediate_value, jump_target,
    jump_absolute, write_accum, write_file, pc_change, two_cycle};
  always #25 mclk = ~mclk;
  tbid_prog_mem #(.N(NR)) tbid_prog_mem_i (.mclk(mclk), .rst_n(rst_n), .words(words),
    .slow(slow), .instr_ready(instr_ready), .instr_word(instr_word),
    .instr_valid(instr_valid));
  tbid_decoder tbid_decoder_i (.mclk(mclk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .test_true(test_true),
    .family(family), .file_addr(file_addr), .position_select(position_select),
    .immediate_value(immediate_value), .jump_target(jump_target),
    .jump_absolute(jump_absolute), .write_accum(write_accum), .write_file(write_file),
    .pc_change(pc_change), .two_cycle(two_cycle), .q_phase(q_phase),
    .cycle_end(cycle_end));
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [33:0] expv(input tbid_row_s r);
    logic [11:0] w;
    logic byt;
    w = r.word;
    byt = r.fam == 2'h0;
    return {r.fam, 2'h0, w[4:0], r.fam == 2'h1 ? w[7:5] : 3'h0, w[7:0], w[8:0],
      w[11:9] == 3'h5, byt && !w[5], byt && w[5], r.pc, r.two};
  endfunction
  // Walk every row; gs is the gap expected for a one-cycle word
  task automatic run(input int gs);
    int last;
    int guard;
    logic [33:0] e;
    last = 0;
    @(negedge mclk);
    for (int k = 0; k < NR; k++) begin
      guard = 0;
      while (!(instr_valid === 1'h1 && instr_ready === 1'h1) && guard < 40) begin
        @(negedge mclk);
        guard++;
      end
      if (guard >= 40) err_total++;
      if (k > 0) begin
        e = expv(ROWS[k-1]);
        // Decoded fields must still hold while the next word waits
        check(40'(actual[33:1]), 40'(e[33:1]));
      end
      @(posedge mclk);
      #2 test_true = ROWS[k].tt;
      if (k > 0) check(40'(cyc - last), ROWS[k-1].two ? 40'h8 : 40'(gs));
      last = cyc;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(40'(actual), 40'(expv(ROWS[k])));
      check(40'({q_phase, cycle_end}), 40'h4);
      @(negedge mclk);
      check(40'({q_phase, cycle_end}), 40'h7);
    end
  endtask
  always @(posedge mclk) begin
    cyc++;
    // Whole run needs well under 1000 cycles
    if (cyc > 2000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    for (int i = 0; i < NR; i++) words[i] = ROWS[i].word;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check(40'({actual, q_phase, instr_ready}), 40'h1);
    @(posedge mclk);
    #2 rst_n = 1'h1;
    run(4);
    // Reset lands while the last word still owes its second cycle
    @(posedge mclk);
    #2 rst_n = 1'h0;
    @(negedge mclk);
    check(40'({actual, q_phase, instr_ready}), 40'h1);
    @(posedge mclk);
    #2 rst_n = 1'h1;
    slow = 1'h1;
    run(7);
    finish_test;
  end
endmodule
`default_nettype wire
